// ---- rtl/gpx_pkg.sv ----
// Constants and types shared by the port expander design
package gpx_pkg;

  // ****************************************
  // Register pointer values
  // ****************************************
  localparam logic [7:0] PTR_INPUT   = 8'h00;
  localparam logic [7:0] PTR_OUTPUT  = 8'h01;
  localparam logic [7:0] PTR_POLAR   = 8'h02;
  localparam logic [7:0] PTR_CONFIG  = 8'h03;
  localparam logic [7:0] PTR_TIMEOUT = 8'h04;

  // ****************************************
  // Reset values and fields
  // ****************************************
  localparam logic [7:0] OUTPUT_RST   = 8'h00;
  localparam logic [7:0] POLAR_RST    = 8'hF0;
  localparam logic [7:0] CONFIG_RST   = 8'hFF;
  localparam logic [7:0] TIMEOUT_RST  = 8'h01;
  localparam logic [7:0] UNMAPPED_RD  = 8'h00;
  localparam int         TMO_EN_BIT   = 0;
  localparam int         OD_PIN       = 0;
  localparam int         NPINS        = 8;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] LAST_TX_BIT  = 4'h7;

  // ****************************************
  // Slave address upper nibble per strap group
  // ****************************************
  localparam logic [3:0] HI_RAILS     = 4'h3;
  localparam logic [3:0] HI_AD1_BUS   = 4'h1;
  localparam logic [3:0] HI_AD0_BUS   = 4'h2;
  localparam logic [3:0] HI_ALL_BUS   = 4'h4;
  localparam logic [3:0] HI_AD21_BUS  = 4'h5;
  localparam logic [3:0] HI_AD20_BUS  = 4'h6;
  localparam logic [3:0] HI_AD2_BUS   = 4'h7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SPIKE_NS       = 50;
  localparam int SPIKE_CYC      = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_MIN_MS = 30;
  localparam int TIMEOUT_MAX_MS = 60;
  localparam int TIMEOUT_CYC    = (TIMEOUT_MIN_MS * 1000000) / CLK_PERIOD_NS;

  // ****************************************
  // Serial engine states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } state_t;

endpackage : gpx_pkg

// ---- rtl/pin_filt_if.sv ----
// Carrier for filtered pin levels between the filter and the core
`timescale 1ns/1ps
interface pin_filt_if #(parameter int W = 5);
  logic [W-1:0] level;
  modport drv (output level);
  modport use_side (input level);
endinterface : pin_filt_if

// ---- rtl/pin_filter.sv ----
// Two-flop synchroniser and spike filter per pin
`timescale 1ns/1ps
module pin_filter #(
  parameter int W    = 5,
  parameter int FILT = gpx_pkg::SPIKE_CYC
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_raw,
  pin_filt_if.drv           filt
);
  import gpx_pkg::*;

  localparam int CW = (FILT < 2) ? 1 : $clog2(FILT + 1);

  if (FILT < 1)
  begin : g_chk
    $error("pin_filter: FILT must be at least 1");
  end

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] level_r;

  // ****************************************
  // Synchroniser
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_r <= '1;
      sync_r <= '1;
    end
    else
    begin
      meta_r <= i_raw;
      sync_r <= meta_r;
    end
  end

  // ****************************************
  // Spike filter per bit
  // ****************************************
  for (genvar g = 0; g < W; g++)
  begin : g_bit
    logic [CW-1:0] cnt_r;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        cnt_r      <= '0;
        level_r[g] <= 1'b1;
      end
      else if (sync_r[g] == level_r[g])
        cnt_r <= '0;
      else if (cnt_r == CW'(FILT - 1))
      begin
        cnt_r      <= '0;
        level_r[g] <= sync_r[g];
      end
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end

  assign filt.level = level_r;

endmodule : pin_filter

// ---- rtl/i2c_eight_bit_port_expander.sv ----
// Eight-bit two-wire port expander core
//
// Function
// - Reset low forces all pins to inputs
// - All pins start as inputs
// - Each pin direction is programmable
// - Set polarity bit inverts returned input of a pin configured as input
// - Timeout enabled at reset, changed only by bus write; O_TIMEOUT_ENABLE_BIT reads 0 until the first clock after reset
// - Long low line resets serial engine
// - Spikes under 50 ns are ignored
// - Address from three four-state strap pins
// - Start, address, pointer, data, stop
// - Idle bus leaves both lines high
// - SDA fall, SCL high starts transaction
// - SDA rise, SCL high ends transaction
// - One bit per pulse, change on low
// - Pin zero is open drain
// - Timeout releases SDA, awaits new start
// - Receiver acknowledges on ninth pulse
// - Bit after address selects direction
// - First data byte is register pointer
`timescale 1ns/1ps
module i2c_eight_bit_port_expander
  import gpx_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = gpx_pkg::TIMEOUT_CYC,
  parameter int SPIKE_CYCLES   = gpx_pkg::SPIKE_CYC
) (
  input  wire logic       I_CLK,
  input  wire logic       I_RST_N,
  input  wire logic       I_SCL,
  input  wire logic       I_SDA,
  output logic            O_SDA,
  output logic            O_SDA_OE,
  input  wire logic       I_ADDR_SELECT_PIN_0,
  input  wire logic       I_ADDR_SELECT_PIN_1,
  input  wire logic       I_ADDR_SELECT_PIN_2,
  input  wire logic       I_OPEN_DRAIN_PORT_PIN,
  output logic            O_OPEN_DRAIN_PORT_PIN,
  output logic            O_OPEN_DRAIN_PORT_PIN_OE,
  input  wire logic [6:0] I_PUSH_PULL_PORT_PINS,
  output logic      [6:0] O_PUSH_PULL_PORT_PINS,
  output logic      [6:0] O_PUSH_PULL_PORT_PINS_OE,
  output logic            O_TIMEOUT_ENABLE_BIT
);
  import gpx_pkg::*;

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  if (TIMEOUT_CYCLES < 1 || SPIKE_CYCLES < 1)
  begin : g_chk
    $error("i2c_eight_bit_port_expander: counts must be at least 1");
  end

  // ****************************************
  // Line filtering
  // ****************************************
  pin_filt_if #(.W(5)) lines ();

  pin_filter #(
    .W    (5),
    .FILT (SPIKE_CYCLES)
  ) u_filt (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_raw   ({I_ADDR_SELECT_PIN_2, I_ADDR_SELECT_PIN_1, I_ADDR_SELECT_PIN_0, I_SDA, I_SCL}),
    .filt    (lines)
  );

  logic       scl;
  logic       sda;
  logic [2:0] ad;
  assign scl = lines.level[0];
  assign sda = lines.level[1];
  assign ad  = lines.level[4:2];

  logic       scl_d_r;
  logic       sda_d_r;
  logic [2:0] ad_d_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      ad_d_r  <= '0;
    end
    else
    begin
      scl_d_r <= scl;
      sda_d_r <= sda;
      ad_d_r  <= ad;
    end
  end

  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  assign start_ev = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_ev  = scl & scl_d_r & ~sda_d_r & sda;

  // ****************************************
  // Port pin input synchroniser
  // ****************************************
  logic [NPINS-1:0] pin_meta_r;
  logic [NPINS-1:0] pin_sync_r;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= {I_PUSH_PULL_PORT_PINS, I_OPEN_DRAIN_PORT_PIN};
      pin_sync_r <= pin_meta_r;
    end
  end

  // ****************************************
  // Strap sensing
  // ****************************************
  logic [2:0] strap_a_r;
  logic [2:0] strap_b_r;
  logic [2:0] strap_c_r;
  logic       first_fall_r;
  logic [2:0] on_bus;
  logic [2:0] low_bits;
  logic [3:0] hi_nib;
  logic       addr_valid;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      strap_a_r    <= '0;
      strap_b_r    <= '0;
      strap_c_r    <= '0;
      first_fall_r <= 1'b0;
    end
    else if (start_ev)
    begin
      strap_a_r    <= ad_d_r;
      strap_b_r    <= ad;
      first_fall_r <= 1'b1;
    end
    else if (first_fall_r && scl_fall)
    begin
      strap_c_r    <= ad;
      first_fall_r <= 1'b0;
    end
  end

  // Ground 000, supply 111, clock line 110, data line 100
  assign on_bus   = strap_a_r & ~strap_c_r;
  assign low_bits = strap_c_r | (on_bus & ~strap_b_r);

  always_comb
  begin
    addr_valid = 1'b1;
    case (on_bus)
      3'h0:    hi_nib = HI_RAILS;
      3'h2:    hi_nib = HI_AD1_BUS;
      3'h1:    hi_nib = HI_AD0_BUS;
      3'h7:    hi_nib = HI_ALL_BUS;
      3'h6:    hi_nib = HI_AD21_BUS;
      3'h5:    hi_nib = HI_AD20_BUS;
      3'h4:    hi_nib = HI_AD2_BUS;
      default:
      begin
        hi_nib     = HI_RAILS;
        addr_valid = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] out_r;
  logic [7:0] pol_r;
  logic [7:0] cfg_r;
  logic [7:0] tmo_r;
  logic [7:0] ptr_r;
  logic       wr_en;
  logic [7:0] rd_data;
  logic [7:0] shift_r;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      out_r <= OUTPUT_RST;
      pol_r <= POLAR_RST;
      cfg_r <= CONFIG_RST;
      tmo_r <= TIMEOUT_RST;
    end
    else if (wr_en)
    begin
      case (ptr_r)
        PTR_OUTPUT:  out_r <= shift_r;
        PTR_POLAR:   pol_r <= shift_r;
        PTR_CONFIG:  cfg_r <= shift_r;
        PTR_TIMEOUT: tmo_r <= shift_r;
        default:     ;
      endcase
    end
  end

  always_comb
  begin
    case (ptr_r)
      PTR_INPUT:   rd_data = pin_sync_r ^ (pol_r & cfg_r);
      PTR_OUTPUT:  rd_data = out_r;
      PTR_POLAR:   rd_data = pol_r;
      PTR_CONFIG:  rd_data = cfg_r;
      PTR_TIMEOUT: rd_data = tmo_r;
      default:     rd_data = UNMAPPED_RD;
    endcase
  end

  // ****************************************
  // Bus timeout
  // ****************************************
  state_t        state_r;
  logic [TW-1:0] tmo_cnt_r;
  logic          tmo_trip;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      tmo_cnt_r <= '0;
    else if (!tmo_r[TMO_EN_BIT] || state_r == ST_IDLE || (scl && sda) || tmo_trip)
      tmo_cnt_r <= '0;
    else
      tmo_cnt_r <= tmo_cnt_r + 1'b1;
  end

  assign tmo_trip = (tmo_cnt_r == TW'(TIMEOUT_CYCLES));

  // ****************************************
  // Serial engine
  // ****************************************
  logic [3:0] bit_cnt_r;
  logic       rw_r;
  logic       sda_oe_r;

  assign wr_en = (state_r == ST_WDATA) && scl_fall && (bit_cnt_r == BYTE_BITS);

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= '0;
      shift_r   <= '0;
      ptr_r     <= PTR_INPUT;
      rw_r      <= 1'b0;
      sda_oe_r  <= 1'b0;
    end
    else if (tmo_trip)
    begin
      state_r  <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end
    else if (start_ev)
    begin
      state_r   <= ST_ADDR;
      bit_cnt_r <= '0;
      sda_oe_r  <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_r  <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          sda_oe_r <= 1'b0;
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          if (scl_rise && bit_cnt_r != BYTE_BITS)
          begin
            shift_r   <= {shift_r[6:0], sda};
            bit_cnt_r <= bit_cnt_r + 1'b1;
          end
          else if (scl_fall && bit_cnt_r == BYTE_BITS)
          begin
            bit_cnt_r <= '0;
            if (state_r == ST_ADDR)
            begin
              if (addr_valid && shift_r[7:1] == {hi_nib, low_bits})
              begin
                rw_r     <= shift_r[0];
                sda_oe_r <= 1'b1;
                state_r  <= ST_ADDR_ACK;
              end
              else
                state_r <= ST_IDLE;
            end
            else if (state_r == ST_PTR)
            begin
              ptr_r    <= shift_r;
              sda_oe_r <= 1'b1;
              state_r  <= ST_PTR_ACK;
            end
            else
            begin
              sda_oe_r <= 1'b1;
              state_r  <= ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_r <= '0;
            if (state_r == ST_ADDR_ACK && rw_r)
            begin
              shift_r  <= {rd_data[6:0], 1'b0};
              sda_oe_r <= ~rd_data[7];
              state_r  <= ST_RDATA;
            end
            else
            begin
              sda_oe_r <= 1'b0;
              state_r  <= (state_r == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_r == LAST_TX_BIT)
            begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_RDATA_ACK;
            end
            else
            begin
              sda_oe_r  <= ~shift_r[7];
              shift_r   <= {shift_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 1'b1;
            end
          end
        end
        ST_RDATA_ACK:
        begin
          if (scl_rise)
            rw_r <= ~sda;
          else if (scl_fall)
          begin
            bit_cnt_r <= '0;
            if (rw_r)
            begin
              shift_r  <= {rd_data[6:0], 1'b0};
              sda_oe_r <= ~rd_data[7];
              state_r  <= ST_RDATA;
            end
            else
              state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r  <= ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  logic [NPINS-1:0] pin_o_r;
  logic [NPINS-1:0] pin_oe_r;

  for (genvar p = 0; p < NPINS; p++)
  begin : g_pin
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
      if (!I_RST_N)
      begin
        pin_o_r[p]  <= 1'b0;
        pin_oe_r[p] <= 1'b0;
      end
      else if (p == OD_PIN)
      begin
        pin_o_r[p]  <= 1'b0;
        pin_oe_r[p] <= ~cfg_r[p] & ~out_r[p];
      end
      else
      begin
        pin_o_r[p]  <= out_r[p];
        pin_oe_r[p] <= ~cfg_r[p];
      end
    end
  end

  logic tmo_en_r;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      tmo_en_r <= 1'b0;
    else
      tmo_en_r <= tmo_r[TMO_EN_BIT];
  end

  logic sda_o_r;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      sda_o_r <= 1'b0;
    else
      sda_o_r <= 1'b0;
  end

  assign O_SDA                    = sda_o_r;
  assign O_SDA_OE                 = sda_oe_r;
  assign O_OPEN_DRAIN_PORT_PIN    = pin_o_r[OD_PIN];
  assign O_OPEN_DRAIN_PORT_PIN_OE = pin_oe_r[OD_PIN];
  assign O_PUSH_PULL_PORT_PINS    = pin_o_r[NPINS-1:1];
  assign O_PUSH_PULL_PORT_PINS_OE = pin_oe_r[NPINS-1:1];
  assign O_TIMEOUT_ENABLE_BIT     = tmo_en_r;

endmodule : i2c_eight_bit_port_expander

// ---- verification/i2c_eight_bit_port_expander_asserts.sv ----
// Port checks for the port expander
`timescale 1ns/1ps
module i2c_eight_bit_port_expander_asserts #(
  parameter int TIMEOUT_CYCLES = 2000
) (
  input wire logic       I_CLK,
  input wire logic       I_RST_N,
  input wire logic       I_SCL,
  input wire logic       I_SDA,
  input wire logic       O_SDA,
  input wire logic       O_SDA_OE,
  input wire logic       O_OPEN_DRAIN_PORT_PIN,
  input wire logic       O_OPEN_DRAIN_PORT_PIN_OE,
  input wire logic [6:0] O_PUSH_PULL_PORT_PINS_OE,
  input wire logic       O_TIMEOUT_ENABLE_BIT
);
  int low_cnt_r;
  // Consecutive cycles of a low line
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      low_cnt_r <= 0;
    else if (O_TIMEOUT_ENABLE_BIT && !(I_SCL && I_SDA))
      low_cnt_r <= low_cnt_r + 1;
    else
      low_cnt_r <= 0;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence start_seq;
    I_SCL && $fell(I_SDA);
  endsequence
  sequence stop_seq;
    I_SCL && $rose(I_SDA);
  endsequence
  a_reset_inputs: assert property ($rose(I_RST_N) |->
    O_PUSH_PULL_PORT_PINS_OE == 7'h00 && !O_OPEN_DRAIN_PORT_PIN_OE) else $error("pins not inputs");
  a_od_low_only: assert property (O_OPEN_DRAIN_PORT_PIN == 1'b0) else $error("pin 0 driven high");
  a_sda_low_only: assert property (O_SDA == 1'b0) else $error("SDA driven high");
  a_sda_change_low: assert property ($changed(O_SDA_OE) |->
    !I_SCL && !$past(I_SCL, 7)) else $error("SDA moved in SCL high");
  a_start_release: assert property (start_seq |-> !O_SDA_OE [*8]) else $error("SDA held at start");
  a_stop_release: assert property (stop_seq |-> !O_SDA_OE [*8]) else $error("SDA held at stop");
  a_timeout_release: assert property (low_cnt_r > TIMEOUT_CYCLES + 12 |->
    !O_SDA_OE) else $error("no release after timeout");
  a_tmo_rst_value: assert property ($rose(I_RST_N) |->
    ##[1:2] O_TIMEOUT_ENABLE_BIT) else $error("timeout enable reset wrong");
  a_tmo_bus_only: assert property ($changed(O_TIMEOUT_ENABLE_BIT) && $past(I_RST_N, 3) |->
    !I_SCL) else $error("timeout enable moved off bus");
  a_pin_change_low: assert property (($changed(O_PUSH_PULL_PORT_PINS_OE) ||
    $changed(O_OPEN_DRAIN_PORT_PIN_OE)) && $past(I_RST_N, 2) |-> !I_SCL) else $error("direction moved");
endmodule : i2c_eight_bit_port_expander_asserts
bind i2c_eight_bit_port_expander i2c_eight_bit_port_expander_asserts #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) chk_u (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE),
  .O_OPEN_DRAIN_PORT_PIN(O_OPEN_DRAIN_PORT_PIN), .O_OPEN_DRAIN_PORT_PIN_OE(O_OPEN_DRAIN_PORT_PIN_OE),
  .O_PUSH_PULL_PORT_PINS_OE(O_PUSH_PULL_PORT_PINS_OE), .O_TIMEOUT_ENABLE_BIT(O_TIMEOUT_ENABLE_BIT)
);

// ---- verification/i2c_bus_master.sv ----
// Two-wire bus master model
`timescale 1ns/1ps
module i2c_bus_master (
  input  wire logic i_lclk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick();
    @(posedge i_lclk);
  endtask : tick
  task automatic start();
    tick();
    o_sda = 1'b1;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b0;
    tick();
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    tick();
    o_sda = 1'b0;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b1;
  endtask : stop
  task automatic bitx(input logic b, output logic r);
    tick();
    o_sda = b;
    tick();
    o_scl = 1'b1;
    tick();
    r = i_sda;
    tick();
    o_scl = 1'b0;
  endtask : bitx
  task automatic wbits(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
  endtask : wbits
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    wbits(d);
    bitx(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask : rbyte
endmodule : i2c_bus_master

// ---- verification/i2c_eight_bit_port_expander_test.sv ----
// Self-checking bench for the port expander
`timescale 1ns/1ps
module i2c_eight_bit_port_expander_test;
  import gpx_pkg::*;
  localparam int TMO = 2000;
  logic       I_CLK = 1'b0;
  logic       I_RST_N = 1'b0;
  logic       lclk = 1'b0;
  logic [7:0] ext = 8'h3C;
  logic [5:0] strap = 6'h00;
  logic [6:0] adr = 7'h18;
  int         err_count = 0;
  int         samples_checked = 0;
  logic       scl, msda, sda_w, o_sda, sda_oe, od_o, od_oe, tmo_bit, pin0;
  logic [6:0] pp_o, pp_oe, pp_i;
  logic [2:0] ad;
  // ****
  // Wires, pins and clocks
  // ****
  assign sda_w = msda & (~sda_oe | o_sda);
  assign pin0  = od_oe ? 1'b0 : ext[0];
  assign pp_i  = (pp_oe & pp_o) | (~pp_oe & ext[7:1]);
  for (genvar g = 0; g < 3; g++)
  begin : g_strap
    assign ad[g] = strap[2*g+1] ? (strap[2*g] ? sda_w : scl) : strap[2*g];
  end
  always #5 I_CLK = ~I_CLK;
  initial
  begin
    #6;
    forever
    begin
      lclk = ~lclk;
      #80;
    end
  end
  i2c_eight_bit_port_expander #(.TIMEOUT_CYCLES(TMO)) dut_u (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_SCL(scl), .I_SDA(sda_w), .O_SDA(o_sda), .O_SDA_OE(sda_oe),
    .I_ADDR_SELECT_PIN_0(ad[0]), .I_ADDR_SELECT_PIN_1(ad[1]), .I_ADDR_SELECT_PIN_2(ad[2]),
    .I_OPEN_DRAIN_PORT_PIN(pin0), .O_OPEN_DRAIN_PORT_PIN(od_o), .O_OPEN_DRAIN_PORT_PIN_OE(od_oe),
    .I_PUSH_PULL_PORT_PINS(pp_i), .O_PUSH_PULL_PORT_PINS(pp_o), .O_PUSH_PULL_PORT_PINS_OE(pp_oe),
    .O_TIMEOUT_ENABLE_BIT(tmo_bit)
  );
  i2c_bus_master m_u (.i_lclk(lclk), .i_sda(sda_w), .o_scl(scl), .o_sda(msda));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [2:0] a;
    m_u.start();
    m_u.wbyte({adr, 1'b0}, a[2]);
    m_u.wbyte(p, a[1]);
    m_u.wbyte(d, a[0]);
    m_u.stop();
    chk({5'h00, a}, 8'h07);
  endtask : wr
  task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
    m_u.start();
    m_u.wbyte({adr, 1'b0}, a[2]);
    m_u.wbyte(p, a[1]);
    m_u.start();
    m_u.wbyte({adr, 1'b1}, a[0]);
    m_u.rbyte(d, 1'b0);
    m_u.rbyte(e, 1'b1);
    m_u.stop();
    chk({5'h00, a}, 8'h07);
    chk(d, exp);
    chk(e, exp);
  endtask : rdc
  // ****
  // Scenarios
  // ****
  task automatic t_reset_vals();
    chk({od_oe, pp_oe}, 8'h00);
    chk({7'h00, tmo_bit}, 8'h01);
    rdc(PTR_OUTPUT, 8'h00);
    rdc(PTR_POLAR, 8'hF0);
    rdc(PTR_CONFIG, 8'hFF);
    rdc(PTR_TIMEOUT, 8'h01);
    rdc(PTR_INPUT, 8'hCC);
    rdc(8'h05, 8'h00);
  endtask : t_reset_vals
  task automatic t_polarity();
    wr(PTR_POLAR, 8'h0F);
    wr(PTR_INPUT, 8'hFF);
    rdc(PTR_INPUT, 8'h33);
  endtask : t_polarity
  task automatic t_direction();
    logic [7:0] cfg [3] = '{8'h00, 8'h00, 8'h0F};
    logic [7:0] out [3] = '{8'hA5, 8'h5A, 8'h5A};
    logic [7:0] inp [3] = '{8'hA4, 8'h5A, 8'h53};
    for (int i = 0; i < 3; i++)
    begin
      wr(PTR_CONFIG, cfg[i]);
      wr(PTR_OUTPUT, out[i]);
      chk({1'b0, pp_oe}, {1'b0, ~cfg[i][7:1]});
      chk({1'b0, pp_o}, {1'b0, out[i][7:1]});
      chk({7'h00, od_oe}, {7'h00, ~cfg[i][0] & ~out[i][0]});
      chk({7'h00, od_o}, 8'h00);
      rdc(PTR_INPUT, inp[i]);
    end
  endtask : t_direction
  task automatic t_reset_mid();
    @(posedge I_CLK);
    #1 I_RST_N = 1'b0;
    repeat (3) @(posedge I_CLK);
    chk({od_oe, pp_oe}, 8'h00);
    #1 I_RST_N = 1'b1;
    rdc(PTR_CONFIG, 8'hFF);
  endtask : t_reset_mid
  task automatic t_straps();
    logic [5:0] md [5] = '{6'h00, 6'h15, 6'h2A, 6'h31, 6'h09};
    logic [6:0] ex [5] = '{7'h18, 7'h1F, 7'h20, 7'h3D, 7'h09};
    logic       a, b;
    for (int i = 0; i < 5; i++)
    begin
      strap = md[i];
      m_u.start();
      m_u.wbyte({ex[i], 1'b0}, a);
      m_u.stop();
      m_u.start();
      m_u.wbyte({ex[i] ^ 7'h01, 1'b0}, b);
      m_u.stop();
      chk({6'h00, a, b}, 8'h02);
    end
    strap = 6'h00;
  endtask : t_straps
  task automatic t_timeout();
    logic [4:0] a;
    m_u.start();
    m_u.wbits({adr, 1'b1});
    repeat (TMO / 2) @(posedge I_CLK);
    #1 a[4] = ~sda_w;
    repeat (TMO / 2 + 600) @(posedge I_CLK);
    #1 a[3] = sda_w;
    m_u.wbyte(PTR_OUTPUT, a[2]);
    m_u.stop();
    wr(PTR_TIMEOUT, 8'h00);
    chk({7'h00, tmo_bit}, 8'h00);
    m_u.start();
    m_u.wbyte({adr, 1'b0}, a[1]);
    repeat (TMO + 600) @(posedge I_CLK);
    m_u.wbyte(PTR_OUTPUT, a[0]);
    m_u.stop();
    chk({3'h0, a}, 8'h1B);
    wr(PTR_TIMEOUT, 8'h01);
  endtask : t_timeout
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (12) @(posedge I_CLK);
    #1 I_RST_N = 1'b1;
    repeat (4) @(posedge I_CLK);
    t_reset_vals();
    t_polarity();
    t_direction();
    t_reset_mid();
    t_straps();
    t_timeout();
    finish_test();
  end
endmodule : i2c_eight_bit_port_expander_test
